/* File: bfu_pkg.sv */
/*
 Shared constants and types of the bit, shift and flag unit.
 Assumes a single core clock and a decoder that presents one operation per cycle.
*/
`default_nettype none

package bfu_pkg;

	// Operation codes from the instruction decoder
	typedef enum logic [4:0] {
		NO_OP = 5'h00,
		STACK_PUSH_OP,
		STACK_POP_OP,
		IO_BIT_SET_OP,
		IO_BIT_CLEAR_OP,
		LOGICAL_LEFT_SHIFT_OP,
		LOGICAL_RIGHT_SHIFT_OP,
		ROTATE_LEFT_CARRY_OP,
		ROTATE_RIGHT_CARRY_OP,
		ARITH_RIGHT_SHIFT_OP,
		NIBBLE_EXCHANGE_OP,
		GENERIC_FLAG_SET_OP,
		GENERIC_FLAG_CLEAR_OP,
		BIT_TO_TRANSFER_FLAG_OP,
		TRANSFER_FLAG_TO_BIT_OP,
		CARRY_SET_OP,
		CARRY_CLEAR_OP,
		NEGATIVE_SET_OP,
		ZERO_CLEAR_OP,
		GLOBAL_IRQ_ENABLE_OP,
		GLOBAL_IRQ_DISABLE_OP,
		OVERFLOW_SET_OP,
		SIGNED_SET_OP
	} bfu_op_e;

	// Bit positions inside the status flags
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// Data and register widths
	localparam int DATA_W = 8;
	localparam int WREG_ADDR_W = 5;
	localparam int IO_ADDR_W = 6;
	localparam int BIT_SEL_W = 3;
	localparam int AXI_ADDR_W = 8;

	// Register map, byte addresses
	localparam logic [AXI_ADDR_W-1:0] REG_FLAGS_OFS = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] REG_STACK_OFS = 8'h04;

	// Flags reset value and default stack depth
	localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
	localparam int STACK_DEPTH_DEF = 16;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

`default_nettype wire

/* File: bfu_stack_mem.sv */
/*
 Small stack memory: one write port, one read port with registered data.
 Assumes the caller keeps addresses in range and owns the stack pointer.
*/
`timescale 1ns/100ps
`default_nettype none

module bfu_stack_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);

	// Storage array, no reset so it maps onto RAM
	logic [WIDTH-1:0] mem_reg [DEPTH];
	// Registered read data
	logic [WIDTH-1:0] rd_data_reg;

	// Write port
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_reg[wr_addr_i] <= wr_data_i;
		end
	end

	// Read port; data stands until the next read
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_reg <= '0;
		end else if (rd_en_i) begin
			rd_data_reg <= mem_reg[rd_addr_i];
		end
	end

	assign rd_data_o = rd_data_reg;

endmodule

`default_nettype wire

/* File: bfu_core.sv */
/*
 Bit, shift, rotate, stack and status-flag execution unit with an AXI4-Lite
 slave for the status flags and stack pointer.
 Assumes the decoder drives operands on the core clock and holds op_valid_i
 low while busy_o is high.
*/
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module bfu_core import bfu_pkg::*; #(
	parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	// Decoder side
	input wire logic op_valid_i,
	input wire bfu_op_e op_code_i,
	input wire logic [WREG_ADDR_W-1:0] rd_addr_i,
	input wire logic [DATA_W-1:0] rd_data_i,
	input wire logic [DATA_W-1:0] source_working_reg_i,
	input wire logic [BIT_SEL_W-1:0] bit_sel_i,
	input wire logic [IO_ADDR_W-1:0] io_addr_i,
	input wire logic [DATA_W-1:0] io_rdata_i,
	output logic busy_o,
	// Register file write
	output logic rd_wr_o,
	output logic [WREG_ADDR_W-1:0] rd_waddr_o,
	output logic [DATA_W-1:0] rd_wdata_o,
	// I/O space write
	output logic io_wr_o,
	output logic [IO_ADDR_W-1:0] io_waddr_o,
	output logic [DATA_W-1:0] io_wdata_o,
	output logic [DATA_W-1:0] status_flags_o,
	// AXI4-Lite slave
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int SPW = $clog2(STACK_DEPTH);

	// Status flags, the architectural state of this unit
	logic [DATA_W-1:0] flags_reg;
	// Stack pointer counts stored entries
	logic [SPW:0] sp_reg;
	logic [SPW:0] sp_dec;
	// Pop in flight: read data lands one cycle later
	logic pop_pend_reg;
	logic [WREG_ADDR_W-1:0] pop_dst_reg;
	logic [DATA_W-1:0] mem_rdata;
	// Result registers toward register file and I/O space
	logic rd_wr_reg;
	logic [WREG_ADDR_W-1:0] rd_waddr_reg;
	logic [DATA_W-1:0] rd_wdata_reg;
	logic io_wr_reg;
	logic [IO_ADDR_W-1:0] io_waddr_reg;
	logic [DATA_W-1:0] io_wdata_reg;
	// Operation taken this cycle
	logic fire;
	logic is_shift;
	logic do_push;
	logic do_pop;
	logic stack_empty;
	logic stack_full;
	// Shifter results
	logic [DATA_W-1:0] sh_res;
	logic sh_c;
	logic sh_n;
	logic sh_v;
	logic [DATA_W-1:0] bit_mask;
	// AXI write channel state
	logic awready_reg;
	logic wready_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [AXI_ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic wr_do;
	// AXI read channel state
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Ops offered while a pop completes are not taken
	assign fire = op_valid_i && !pop_pend_reg;
	assign stack_empty = (sp_reg == '0);
	assign stack_full = (sp_reg == (SPW+1)'(STACK_DEPTH));
	// Push on full and pop on empty are dropped rather than wrapping
	assign do_push = fire && (op_code_i == STACK_PUSH_OP) && !stack_full;
	assign do_pop = fire && (op_code_i == STACK_POP_OP) && !stack_empty;
	assign sp_dec = sp_reg - 1'b1;
	assign bit_mask = 8'h01 << bit_sel_i;

	// One-hot style decode of the shift group
	assign is_shift = (op_code_i == LOGICAL_LEFT_SHIFT_OP) ||
		(op_code_i == LOGICAL_RIGHT_SHIFT_OP) ||
		(op_code_i == ROTATE_LEFT_CARRY_OP) ||
		(op_code_i == ROTATE_RIGHT_CARRY_OP) ||
		(op_code_i == ARITH_RIGHT_SHIFT_OP);

	// Shifter: result and the bit that falls out
	always_comb begin
		case (op_code_i)
			LOGICAL_LEFT_SHIFT_OP: begin
				sh_res = {rd_data_i[6:0], 1'b0};
				sh_c = rd_data_i[7];
			end
			LOGICAL_RIGHT_SHIFT_OP: begin
				sh_res = {1'b0, rd_data_i[7:1]};
				sh_c = rd_data_i[0];
			end
			ROTATE_LEFT_CARRY_OP: begin
				sh_res = {rd_data_i[6:0], flags_reg[FLAG_C]};
				sh_c = rd_data_i[7];
			end
			ROTATE_RIGHT_CARRY_OP: begin
				sh_res = {flags_reg[FLAG_C], rd_data_i[7:1]};
				sh_c = rd_data_i[0];
			end
			ARITH_RIGHT_SHIFT_OP: begin
				sh_res = {rd_data_i[7], rd_data_i[7:1]};
				sh_c = rd_data_i[0];
			end
			default: begin
				sh_res = rd_data_i;
				sh_c = flags_reg[FLAG_C];
			end
		endcase
	end

	// Overflow after a shift is negative xor carry
	assign sh_n = sh_res[7];
	assign sh_v = sh_n ^ sh_c;

	// Status flags; an instruction wins over a bus write in the same cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags_reg <= FLAGS_RST;
		end else if (fire && is_shift) begin
			flags_reg[FLAG_C] <= sh_c;
			flags_reg[FLAG_Z] <= (sh_res == '0);
			flags_reg[FLAG_N] <= sh_n;
			flags_reg[FLAG_V] <= sh_v;
			flags_reg[FLAG_S] <= sh_n ^ sh_v;
		end else if (fire) begin
			case (op_code_i)
				GENERIC_FLAG_SET_OP: flags_reg <= flags_reg | bit_mask;
				GENERIC_FLAG_CLEAR_OP: flags_reg <= flags_reg & ~bit_mask;
				BIT_TO_TRANSFER_FLAG_OP: begin
					flags_reg[FLAG_T] <= source_working_reg_i[bit_sel_i];
				end
				CARRY_SET_OP: flags_reg[FLAG_C] <= 1'b1;
				CARRY_CLEAR_OP: flags_reg[FLAG_C] <= 1'b0;
				NEGATIVE_SET_OP: flags_reg[FLAG_N] <= 1'b1;
				ZERO_CLEAR_OP: flags_reg[FLAG_Z] <= 1'b0;
				GLOBAL_IRQ_ENABLE_OP: flags_reg[FLAG_I] <= 1'b1;
				GLOBAL_IRQ_DISABLE_OP: flags_reg[FLAG_I] <= 1'b0;
				OVERFLOW_SET_OP: flags_reg[FLAG_V] <= 1'b1;
				SIGNED_SET_OP: flags_reg[FLAG_S] <= 1'b1;
				default: begin
					if (wr_do && wstrb0_reg && awaddr_reg == REG_FLAGS_OFS) begin
						flags_reg <= wdata_reg[DATA_W-1:0];
					end
				end
			endcase
		end else if (wr_do && wstrb0_reg && awaddr_reg == REG_FLAGS_OFS) begin
			// Software may preload the flags while the core is idle
			flags_reg <= wdata_reg[DATA_W-1:0];
		end
	end

	// Stack pointer moves with each accepted push or pop
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sp_reg <= '0;
		end else if (do_push) begin
			sp_reg <= sp_reg + 1'b1;
		end else if (do_pop) begin
			sp_reg <= sp_dec;
		end
	end

	// Remember the pop target until the memory data arrive
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pop_pend_reg <= 1'b0;
			pop_dst_reg <= '0;
		end else begin
			pop_pend_reg <= do_pop;
			if (do_pop) begin
				pop_dst_reg <= rd_addr_i;
			end
		end
	end

	// Stack storage; pushes write at the top, pops read just below it
	bfu_stack_mem #(
		.WIDTH(DATA_W),
		.DEPTH(STACK_DEPTH),
		.AW(SPW)
	) u_stack (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.wr_en_i(do_push),
		.wr_addr_i(sp_reg[SPW-1:0]),
		.wr_data_i(source_working_reg_i),
		.rd_en_i(do_pop),
		.rd_addr_i(sp_dec[SPW-1:0]),
		.rd_data_o(mem_rdata)
	);

	// Register file results, ready one edge after the op is taken, two edges for a pop
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_wr_reg <= 1'b0;
			rd_waddr_reg <= '0;
			rd_wdata_reg <= '0;
		end else if (pop_pend_reg) begin
			rd_wr_reg <= 1'b1;
			rd_waddr_reg <= pop_dst_reg;
			rd_wdata_reg <= mem_rdata;
		end else if (fire && is_shift) begin
			rd_wr_reg <= 1'b1;
			rd_waddr_reg <= rd_addr_i;
			rd_wdata_reg <= sh_res;
		end else if (fire && op_code_i == NIBBLE_EXCHANGE_OP) begin
			rd_wr_reg <= 1'b1;
			rd_waddr_reg <= rd_addr_i;
			rd_wdata_reg <= {rd_data_i[3:0], rd_data_i[7:4]};
		end else if (fire && op_code_i == TRANSFER_FLAG_TO_BIT_OP) begin
			rd_wr_reg <= 1'b1;
			rd_waddr_reg <= rd_addr_i;
			// Only the selected bit changes
			rd_wdata_reg <= (rd_data_i & ~bit_mask) |
				(flags_reg[FLAG_T] ? bit_mask : 8'h00);
		end else begin
			rd_wr_reg <= 1'b0;
		end
	end

	// I/O read-modify-write; the decoder supplies the current value
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_wr_reg <= 1'b0;
			io_waddr_reg <= '0;
			io_wdata_reg <= '0;
		end else if (fire && op_code_i == IO_BIT_SET_OP) begin
			io_wr_reg <= 1'b1;
			io_waddr_reg <= io_addr_i;
			io_wdata_reg <= io_rdata_i | bit_mask;
		end else if (fire && op_code_i == IO_BIT_CLEAR_OP) begin
			io_wr_reg <= 1'b1;
			io_waddr_reg <= io_addr_i;
			io_wdata_reg <= io_rdata_i & ~bit_mask;
		end else begin
			io_wr_reg <= 1'b0;
		end
	end

	// Bus write: address and data taken in either order
	assign wr_do = aw_got_reg && w_got_reg && !bvalid_reg;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_got_reg <= 1'b1;
				awready_reg <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_got_reg <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				// Only the flags register is writable
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (awaddr_reg == REG_FLAGS_OFS ||
					awaddr_reg == REG_STACK_OFS) ? RESP_OKAY : RESP_DECERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// Bus read: one word per request, answered the next cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			case (s_axi_araddr)
				REG_FLAGS_OFS: begin
					rdata_reg <= 32'(flags_reg);
					rresp_reg <= RESP_OKAY;
				end
				REG_STACK_OFS: begin
					rdata_reg <= 32'(sp_reg);
					rresp_reg <= RESP_OKAY;
				end
				default: begin
					rdata_reg <= '0;
					rresp_reg <= RESP_DECERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Outputs straight from flip-flops
	assign busy_o = pop_pend_reg;
	assign rd_wr_o = rd_wr_reg;
	assign rd_waddr_o = rd_waddr_reg;
	assign rd_wdata_o = rd_wdata_reg;
	assign io_wr_o = io_wr_reg;
	assign io_waddr_o = io_waddr_reg;
	assign io_wdata_o = io_wdata_reg;
	assign status_flags_o = flags_reg;
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Helper copies of last-cycle operands for the checks below
	logic [DATA_W-1:0] p_rd_reg;
	logic [DATA_W-1:0] p_rr_reg;
	logic [DATA_W-1:0] p_io_reg;
	logic [DATA_W-1:0] p_fl_reg;
	logic [DATA_W-1:0] p_mask_reg;
	logic [BIT_SEL_W-1:0] p_sel_reg;
	always_ff @(posedge clk_i) begin
		p_rd_reg <= rd_data_i;
		p_rr_reg <= source_working_reg_i;
		p_io_reg <= io_rdata_i;
		p_fl_reg <= flags_reg;
		p_mask_reg <= bit_mask;
		p_sel_reg <= bit_sel_i;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_lsl;
		fire && op_code_i == LOGICAL_LEFT_SHIFT_OP |=> rd_wr_o &&
			rd_wdata_o == {p_rd_reg[6:0], 1'b0} && status_flags_o[FLAG_C] == p_rd_reg[7];
	endproperty
	a_lsl: assert property (p_lsl) else $error("left shift wrong");

	property p_lsr;
		fire && op_code_i == LOGICAL_RIGHT_SHIFT_OP |=> rd_wdata_o == {1'b0, p_rd_reg[7:1]}
			&& status_flags_o[FLAG_Z] == (rd_wdata_o == 8'h00);
	endproperty
	a_lsr: assert property (p_lsr) else $error("right shift wrong");

	property p_rol;
		fire && op_code_i == ROTATE_LEFT_CARRY_OP |=>
			rd_wdata_o == {p_rd_reg[6:0], p_fl_reg[FLAG_C]} && status_flags_o[FLAG_C] == p_rd_reg[7];
	endproperty
	a_rol: assert property (p_rol) else $error("left rotate wrong");

	property p_ror;
		fire && op_code_i == ROTATE_RIGHT_CARRY_OP |=>
			rd_wdata_o == {p_fl_reg[FLAG_C], p_rd_reg[7:1]} && status_flags_o[FLAG_C] == p_rd_reg[0];
	endproperty
	a_ror: assert property (p_ror) else $error("right rotate wrong");

	property p_asr;
		fire && op_code_i == ARITH_RIGHT_SHIFT_OP |=> rd_wdata_o == {p_rd_reg[7], p_rd_reg[7:1]}
			&& status_flags_o[FLAG_V] == (status_flags_o[FLAG_N] ^ status_flags_o[FLAG_C]);
	endproperty
	a_asr: assert property (p_asr) else $error("arithmetic shift wrong");

	property p_swap;
		fire && op_code_i == NIBBLE_EXCHANGE_OP |=> rd_wr_o && rd_wdata_o == {p_rd_reg[3:0], p_rd_reg[7:4]};
	endproperty
	a_swap: assert property (p_swap) else $error("nibble exchange wrong");

	property p_ioset;
		fire && op_code_i == IO_BIT_SET_OP |=> io_wr_o && io_wdata_o == (p_io_reg | p_mask_reg);
	endproperty
	a_ioset: assert property (p_ioset) else $error("io bit set wrong");

	property p_ioclr;
		fire && op_code_i == IO_BIT_CLEAR_OP |=> io_wr_o && io_wdata_o == (p_io_reg & ~p_mask_reg);
	endproperty
	a_ioclr: assert property (p_ioclr) else $error("io bit clear wrong");

	property p_bst;
		fire && op_code_i == BIT_TO_TRANSFER_FLAG_OP |=> status_flags_o[FLAG_T] == p_rr_reg[p_sel_reg];
	endproperty
	a_bst: assert property (p_bst) else $error("bit store wrong");

	property p_generic_flag_set_op;
		fire && op_code_i == GENERIC_FLAG_SET_OP |=> status_flags_o == (p_fl_reg | p_mask_reg);
	endproperty
	a_generic_flag_set_op: assert property (p_generic_flag_set_op) else $error("flag set wrong");

	property p_cli;
		fire && op_code_i == GLOBAL_IRQ_DISABLE_OP |=> !status_flags_o[FLAG_I];
	endproperty
	a_cli: assert property (p_cli) else $error("interrupt disable wrong");

	property p_pushpop;
		fire && op_code_i == STACK_PUSH_OP && !stack_full ##1 fire && op_code_i == STACK_POP_OP
			|=> ##1 rd_wr_o && rd_wdata_o == $past(source_working_reg_i, 3);
	endproperty
	a_pushpop: assert property (p_pushpop) else $error("stack round trip wrong");

	c_pop: cover property (do_pop ##2 rd_wr_o);
	c_rol: cover property (fire && op_code_i == ROTATE_LEFT_CARRY_OP);
	c_busw: cover property (wr_do ##1 s_axi_bvalid);

endmodule

`default_nettype wire

/* File: bfu_regfile_model.sv */
/*
 Behavioural register file and I/O space that face the unit.
 Assumes the unit reads operands combinationally and writes on one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none

module bfu_regfile_model import bfu_pkg::*; (
	input wire logic clk_i,
	input wire logic [WREG_ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0] rd_data_o,
	input wire logic [IO_ADDR_W-1:0] io_addr_i,
	output logic [DATA_W-1:0] io_rdata_o,
	input wire logic rd_wr_i,
	input wire logic [WREG_ADDR_W-1:0] rd_waddr_i,
	input wire logic [DATA_W-1:0] rd_wdata_i,
	input wire logic io_wr_i,
	input wire logic [IO_ADDR_W-1:0] io_waddr_i,
	input wire logic [DATA_W-1:0] io_wdata_i
);
	// Storage; seeded with a pattern the bench model repeats
	logic [DATA_W-1:0] wreg [32];
	logic [DATA_W-1:0] ioreg [64];

	// Distinct start values so a wrong address shows up
	initial begin
		for (int i = 0; i < 64; i++) begin
			if (i < 32) wreg[i] = 8'(i * 37 + 3);
			ioreg[i] = 8'(i * 53 + 9);
		end
	end

	// Operands are always driven, never left floating
	assign rd_data_o = wreg[rd_addr_i];
	assign io_rdata_o = ioreg[io_addr_i];

	// Write pulses land at the clock edge
	always @(posedge clk_i) begin
		if (rd_wr_i) wreg[rd_waddr_i] <= rd_wdata_i;
		if (io_wr_i) ioreg[io_waddr_i] <= io_wdata_i;
	end
endmodule

`default_nettype wire

/* File: bfu_core_tb.sv */
/*
 Self-checking bench of the unit against an integer and queue model.
 Assumes the package constants and the hand-over timing of the unit.
*/
`timescale 1ns/100ps
`default_nettype none

module bfu_core_tb import bfu_pkg::*;;
	logic clk_i = 0, rstn_i = 0, op_valid_i = 0;
	bfu_op_e op_code_i = NO_OP;
	logic [4:0] rd_addr_i = 0;
	logic [7:0] source_working_reg_i = 0;
	logic [2:0] bit_sel_i = 0;
	logic [5:0] io_addr_i = 0;
	wire logic [7:0] rd_data_i, io_rdata_i, rd_wdata_o, io_wdata_o, status_flags_o;
	wire logic busy_o, rd_wr_o, io_wr_o;
	wire logic [4:0] rd_waddr_o;
	wire logic [5:0] io_waddr_o;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	// Bench model state
	logic [7:0] mr [32];
	logic [7:0] mio [64];
	logic [7:0] mf = 0;
	logic [7:0] stk [$];
	int fail_count = 0, checked = 0;

	always #10 clk_i = ~clk_i;

	bfu_core u_dut (.clk_i, .rstn_i, .op_valid_i, .op_code_i, .rd_addr_i, .rd_data_i,
		.source_working_reg_i, .bit_sel_i, .io_addr_i, .io_rdata_i, .busy_o, .rd_wr_o,
		.rd_waddr_o, .rd_wdata_o, .io_wr_o, .io_waddr_o, .io_wdata_o, .status_flags_o,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	bfu_regfile_model u_far (.clk_i, .rd_addr_i, .rd_data_o(rd_data_i), .io_addr_i,
		.io_rdata_o(io_rdata_i), .rd_wr_i(rd_wr_o), .rd_waddr_i(rd_waddr_o),
		.rd_wdata_i(rd_wdata_o), .io_wr_i(io_wr_o), .io_waddr_i(io_waddr_o),
		.io_wdata_i(io_wdata_o));

	// Verdict; the single place the run ends
	task complete_run;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task chk1(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %b got %b", n, e, g);
		end
	endtask

	task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask

	task chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask

	// A wait that ran out is a mismatch and ends the run
	task tmo(input int n);
		if (n >= 50) begin
			fail_count++;
			$display("ERROR handshake exp done got timeout");
			complete_run;
		end
	endtask

	// Address and data offered together, each released when taken
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		tmo(n);
		s_axi_bready <= 0;
		chk8("bresp", {6'h00, er}, {6'h00, s_axi_bresp});
	endtask

	task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		tmo(n);
		s_axi_rready <= 0;
		chk8("rresp", {6'h00, er}, {6'h00, s_axi_rresp});
		chk32("rdata", e, s_axi_rdata);
	endtask

	// One operation, expectation worked out before the unit answers
	task do_op(input bfu_op_e o, input logic [4:0] r, input logic [2:0] b,
			input logic [5:0] a, input logic [7:0] s);
		logic [7:0] m, x, eio;
		logic ew, ei;
		m = mr[r];
		x = m;
		eio = mio[a];
		ew = o inside {[LOGICAL_LEFT_SHIFT_OP:NIBBLE_EXCHANGE_OP], TRANSFER_FLAG_TO_BIT_OP};
		ei = o inside {IO_BIT_SET_OP, IO_BIT_CLEAR_OP};
		@(posedge clk_i);
		op_valid_i <= 1;
		op_code_i <= o;
		rd_addr_i <= r;
		bit_sel_i <= b;
		io_addr_i <= a;
		source_working_reg_i <= s;
		case (o)
			STACK_PUSH_OP: if (stk.size() < STACK_DEPTH_DEF) stk.push_back(s);
			STACK_POP_OP: if (stk.size() > 0) begin
				ew = 1;
				x = stk.pop_back();
			end
			IO_BIT_SET_OP: eio = eio | (8'h01 << b);
			IO_BIT_CLEAR_OP: eio = eio & ~(8'h01 << b);
			LOGICAL_LEFT_SHIFT_OP: {mf[FLAG_C], x} = {m, 1'b0};
			LOGICAL_RIGHT_SHIFT_OP: {x, mf[FLAG_C]} = {1'b0, m};
			ROTATE_LEFT_CARRY_OP: {mf[FLAG_C], x} = {m, mf[FLAG_C]};
			ROTATE_RIGHT_CARRY_OP: {x, mf[FLAG_C]} = {mf[FLAG_C], m};
			ARITH_RIGHT_SHIFT_OP: {x, mf[FLAG_C]} = {m[7], m};
			NIBBLE_EXCHANGE_OP: x = {m[3:0], m[7:4]};
			GENERIC_FLAG_SET_OP: mf[b] = 1;
			GENERIC_FLAG_CLEAR_OP: mf[b] = 0;
			BIT_TO_TRANSFER_FLAG_OP: mf[FLAG_T] = s[b];
			TRANSFER_FLAG_TO_BIT_OP: x[b] = mf[FLAG_T];
			CARRY_SET_OP: mf[FLAG_C] = 1;
			CARRY_CLEAR_OP: mf[FLAG_C] = 0;
			NEGATIVE_SET_OP: mf[FLAG_N] = 1;
			ZERO_CLEAR_OP: mf[FLAG_Z] = 0;
			GLOBAL_IRQ_ENABLE_OP: mf[FLAG_I] = 1;
			GLOBAL_IRQ_DISABLE_OP: mf[FLAG_I] = 0;
			OVERFLOW_SET_OP: mf[FLAG_V] = 1;
			SIGNED_SET_OP: mf[FLAG_S] = 1;
			default: ;
		endcase
		// Shifts and rotates refresh the result flags; swap leaves them
		if (o inside {[LOGICAL_LEFT_SHIFT_OP:ARITH_RIGHT_SHIFT_OP]}) begin
			mf[FLAG_Z] = (x == 0);
			mf[FLAG_N] = x[7];
			mf[FLAG_V] = x[7] ^ mf[FLAG_C];
			mf[FLAG_S] = mf[FLAG_N] ^ mf[FLAG_V];
		end
		@(posedge clk_i);
		op_valid_i <= 0;
		if (o == STACK_POP_OP) begin
			@(posedge clk_i);
			chk1("busy", ew, busy_o);
		end
		@(posedge clk_i);
		chk1("rd_wr", ew, rd_wr_o);
		if (ew) begin
			chk8("rd_wdata", x, rd_wdata_o);
			chk8("rd_waddr", {3'h0, r}, {3'h0, rd_waddr_o});
			mr[r] = x;
		end
		chk1("io_wr", ei, io_wr_o);
		if (ei) begin
			chk8("io_wdata", eio, io_wdata_o);
			chk8("io_waddr", {2'h0, a}, {2'h0, io_waddr_o});
			mio[a] = eio;
		end
		chk8("flags", mf, status_flags_o);
	endtask

	// Push then pop on consecutive edges; unless the stack was full, the pop must return the byte just pushed
	task push_pop(input logic [4:0] r, input logic [7:0] s);
		logic [7:0] x;
		if (stk.size() < STACK_DEPTH_DEF) stk.push_back(s);
		x = stk.pop_back();
		@(posedge clk_i);
		op_valid_i <= 1;
		op_code_i <= STACK_PUSH_OP;
		rd_addr_i <= r;
		source_working_reg_i <= s;
		@(posedge clk_i);
		op_code_i <= STACK_POP_OP;
		@(posedge clk_i);
		op_valid_i <= 0;
		repeat (2) @(posedge clk_i);
		chk1("rd_wr", 1'b1, rd_wr_o);
		chk8("rd_wdata", x, rd_wdata_o);
		chk8("rd_waddr", {3'h0, r}, {3'h0, rd_waddr_o});
		mr[r] = x;
	endtask

	// Main sequence
	initial begin
		for (int i = 0; i < 64; i++) begin
			if (i < 32) mr[i] = 8'(i * 37 + 3);
			mio[i] = 8'(i * 53 + 9);
		end
		repeat (8) @(posedge clk_i);
		rstn_i <= 1;
		void'($urandom(72));
		// Every code once except NO_OP
		for (int i = 1; i <= 22; i++)
			do_op(bfu_op_e'(i), 5'($urandom), 3'($urandom), 6'($urandom), 8'($urandom));
		// Overfill, count, then drain past empty
		repeat (18) do_op(STACK_PUSH_OP, 0, 0, 0, 8'($urandom));
		axi_rd(REG_STACK_OFS, 32'(stk.size()), RESP_OKAY);
		repeat (18) do_op(STACK_POP_OP, 5'($urandom), 0, 0, 0);
		// Random mix
		repeat (300) do_op(bfu_op_e'($urandom_range(22, 1)), 5'($urandom), 3'($urandom),
			6'($urandom), 8'($urandom));
		// Back-to-back push and pop round trips
		repeat (4) push_pop(5'($urandom), 8'($urandom));
		// Flags over the bus, refused places, read-only count
		mf = 8'($urandom);
		axi_wr(REG_FLAGS_OFS, {24'h0000_00, mf}, RESP_OKAY);
		axi_rd(REG_FLAGS_OFS, {24'h0000_00, mf}, RESP_OKAY);
		axi_wr(8'h08, 32'hffff_ffff, RESP_DECERR);
		axi_rd(8'h08, 32'h0000_0000, RESP_DECERR);
		axi_wr(REG_STACK_OFS, 32'h0000_0005, RESP_OKAY);
		axi_rd(REG_STACK_OFS, 32'(stk.size()), RESP_OKAY);
		do_op(ROTATE_RIGHT_CARRY_OP, 5'h03, 0, 0, 0);
		complete_run;
	end
endmodule

`default_nettype wire
